// file: core/conv_ctrl_pkg.sv
// Shared constants for the converter result and trigger control block.
// Assumes a single 50 MHz system clock and an 8-bit register port.
package conv_ctrl_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] OFF_CONTROL_STATUS = 3'h0;
  localparam logic [2:0] OFF_RESULT_LOW     = 3'h1;
  localparam logic [2:0] OFF_RESULT_HIGH    = 3'h2;
  localparam logic [2:0] OFF_SPECIAL_IO     = 3'h3;
  localparam logic [2:0] OFF_INPUT_SELECT   = 3'h4;
  localparam logic [2:0] OFF_IRQ_STATUS     = 3'h5;
  localparam logic [2:0] OFF_IRQ_MASK       = 3'h6;

  // Control/status field positions
  localparam int BIT_CONVERTER_ENABLE  = 7;
  localparam int BIT_START_CONVERSION  = 6;
  localparam int BIT_AUTO_TRIGGER      = 5;
  localparam int BIT_COMPLETE_FLAG     = 4;
  localparam int BIT_IRQ_ENABLE        = 3;
  localparam int POS_DIVIDER_SELECT    = 0;

  // Special function field positions
  localparam int POS_TRIGGER_SELECT    = 5;
  localparam int BIT_HIGH_SPEED        = 4;

  // Input select field positions
  localparam int BIT_LEFT_ADJUST       = 5;
  localparam int POS_CHANNEL_SELECT    = 0;

  // Interrupt status bit positions
  localparam int IRQ_BIT_COMPLETE      = 0;
  localparam int IRQ_BIT_TRIGGER       = 1;

  // Reset values
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [9:0] RESET_RESULT  = 10'h000;

  // Channel codes from DIFF_FIRST up to DIFF_LAST select differential pairs
  localparam logic [4:0] DIFF_FIRST    = 5'h08;
  localparam logic [4:0] DIFF_LAST     = 5'h1D;

  // Converter timing, in converter clock cycles
  localparam int FIRST_CONV_CYCLES     = 25;
  localparam int NORMAL_CONV_CYCLES    = 13;

  // Trigger source codes
  typedef enum logic [2:0] {
    TRIG_FREE_RUN, TRIG_COMPARATOR, TRIG_EXT_IRQ0, TRIG_T0_COMPARE,
    TRIG_T0_OVERFLOW, TRIG_COMPARE_B, TRIG_T1_OVERFLOW, TRIG_T1_CAPTURE
  } trigger_source_t;

endpackage

// file: core/conv_prescaler.sv
// Converter clock prescaler: turns the system clock into a one-cycle
// converter tick at a selectable division ratio.
// Assumes the caller holds run low while the converter is disabled.
`timescale 1ns/1ps
`default_nettype none
module conv_prescaler (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [2:0] clock_divider_select,
  output logic            tick
);
  import conv_ctrl_pkg::*;

  typedef struct packed {
    logic [6:0] count;
    logic       tick;
  } presc_state_t;

  presc_state_t state;
  presc_state_t next_state;
  logic [6:0]   limit;

  // Division factor minus one; codes 0 and 1 both divide by two
  always_comb begin
    case (clock_divider_select)
      3'h0, 3'h1: limit = 7'h01;
      3'h2:       limit = 7'h03;
      3'h3:       limit = 7'h07;
      3'h4:       limit = 7'h0F;
      3'h5:       limit = 7'h1F;
      3'h6:       limit = 7'h3F;
      default:    limit = 7'h7F;
    endcase
  end

  // Free counter restarted when stopped so the first tick is a full period
  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (!run) begin
      next_state.count = 7'h00;
    end else if (state.count >= limit) begin
      next_state.count = 7'h00;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule
`default_nettype wire

// file: core/conv_result_ctrl.sv
// Converter result and trigger control: registers, result formatting,
// read lock, auto-trigger edge detection and the completion interrupt.
// Assumes a single system clock; the analog core reports each finished
// conversion with a one-cycle done pulse and its 10-bit code.
`timescale 1ns/1ps
`default_nettype none
module conv_result_ctrl (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       global_irq_enable,
  input  wire logic       irq_vector_taken,
  input  wire logic [7:1] trigger_flags,
  input  wire logic       conv_done,
  input  wire logic [9:0] conv_data,
  output logic            conv_start,
  output logic            conv_first,
  output logic            conv_tick,
  output logic            converter_on,
  output logic            high_speed_select,
  output logic      [4:0] channel_select_bits,
  output logic            conv_irq,
  output logic            irq
);
  import conv_ctrl_pkg::*;

  typedef struct packed {
    logic            converter_enable;
    logic            busy;
    logic            auto_trigger_enable;
    logic            conv_complete_flag;
    logic            conv_irq_enable;
    logic [2:0]      clock_divider_select;
    trigger_source_t trigger_source_select;
    logic            high_speed_select;
    logic [3:0]      special_low;
    logic            left_adjust;
    logic [1:0]      input_select_top;
    logic [4:0]      channel_select_bits;
    logic [9:0]      conversion_result;
    logic            result_signed;
    logic            result_locked;
    logic            need_init;
    logic            pending_start;
    logic            first;
    logic            start;
    logic            prev_trigger;
    logic [1:0]      irq_status;
    logic [1:0]      irq_mask;
    logic [7:0]      rdata;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [7:0]  trigger_vector;
  logic        selected_trigger;
  logic        trigger_edge;
  logic [7:0]  result_low_byte;
  logic [7:0]  result_high_byte;
  logic [9:0]  shown_result;
  logic        differential;
  logic        write_start;

  // Prescaler runs only while the converter is enabled
  conv_prescaler u_prescaler (
    .clk                  (clk),
    .rstn                 (rstn),
    .run                  (state.converter_enable),
    .clock_divider_select (state.clock_divider_select),
    .tick                 (conv_tick)
  );

  // Source 0 is the completion flag itself so free-run retriggers on it
  assign trigger_vector   = {trigger_flags, state.conv_complete_flag};
  assign selected_trigger = trigger_vector[state.trigger_source_select];
  // The previous sample is the old selection, so a source switch other than into free run looks like an edge
  assign trigger_edge     = state.auto_trigger_enable && selected_trigger && !state.prev_trigger;

  // Differential codes give a sign-extended two's complement code
  assign differential = (state.channel_select_bits >= DIFF_FIRST) &&
                        (state.channel_select_bits <= DIFF_LAST);

  // Presentation follows left_adjust live, not the value at conversion time
  assign shown_result = state.conversion_result;
  always_comb begin
    if (state.left_adjust) begin
      result_high_byte = shown_result[9:2];
      result_low_byte  = {shown_result[1:0], 6'h00};
    end else if (state.result_signed) begin
      result_high_byte = {{6{shown_result[9]}}, shown_result[9:8]};
      result_low_byte  = shown_result[7:0];
    end else begin
      result_high_byte = {6'h00, shown_result[9:8]};
      result_low_byte  = shown_result[7:0];
    end
  end

  assign write_start = reg_write && (reg_addr == OFF_CONTROL_STATUS) &&
                       reg_wdata[BIT_START_CONVERSION];

  // Register writes, read side effects, trigger and conversion tracking
  always_comb begin
    next_state       = state;
    next_state.start = 1'b0;
    next_state.first = 1'b0;
    next_state.rdata = RESET_BYTE;
    next_state.prev_trigger = selected_trigger;

    if (reg_write) begin
      case (reg_addr)
        OFF_CONTROL_STATUS: begin
          next_state.converter_enable     = reg_wdata[BIT_CONVERTER_ENABLE];
          next_state.auto_trigger_enable  = reg_wdata[BIT_AUTO_TRIGGER];
          next_state.conv_irq_enable      = reg_wdata[BIT_IRQ_ENABLE];
          next_state.clock_divider_select = reg_wdata[POS_DIVIDER_SELECT +: 3];
          if (reg_wdata[BIT_COMPLETE_FLAG]) begin
            next_state.conv_complete_flag = 1'b0;
          end
          if (!state.converter_enable && reg_wdata[BIT_CONVERTER_ENABLE]) begin
            next_state.need_init = 1'b1;
          end
        end
        OFF_SPECIAL_IO: begin
          next_state.trigger_source_select = trigger_source_t'(reg_wdata[POS_TRIGGER_SELECT +: 3]);
          next_state.high_speed_select     = reg_wdata[BIT_HIGH_SPEED];
          next_state.special_low           = reg_wdata[3:0];
        end
        OFF_INPUT_SELECT: begin
          next_state.input_select_top    = reg_wdata[7:6];
          next_state.left_adjust         = reg_wdata[BIT_LEFT_ADJUST];
          next_state.channel_select_bits = reg_wdata[POS_CHANNEL_SELECT +: 5];
        end
        OFF_IRQ_MASK: next_state.irq_mask = reg_wdata[1:0];
        default: ;
      endcase
    end

    if (reg_read) begin
      case (reg_addr)
        OFF_CONTROL_STATUS: next_state.rdata = {state.converter_enable, state.busy,
          state.auto_trigger_enable, state.conv_complete_flag, state.conv_irq_enable,
          state.clock_divider_select};
        OFF_RESULT_LOW: begin
          next_state.rdata         = result_low_byte;
          next_state.result_locked = 1'b1;
        end
        OFF_RESULT_HIGH: begin
          next_state.rdata         = result_high_byte;
          next_state.result_locked = 1'b0;
        end
        OFF_SPECIAL_IO: next_state.rdata = {state.trigger_source_select,
          state.high_speed_select, state.special_low};
        OFF_INPUT_SELECT: next_state.rdata = {state.input_select_top,
          state.left_adjust, state.channel_select_bits};
        OFF_IRQ_STATUS: begin
          next_state.rdata      = {6'h00, state.irq_status};
          next_state.irq_status = 2'h0;
        end
        OFF_IRQ_MASK: next_state.rdata = {6'h00, state.irq_mask};
        default: next_state.rdata = RESET_BYTE;
      endcase
    end

    // Vector taken clears the flag; write-one clear handled above
    if (irq_vector_taken) begin
      next_state.conv_complete_flag = 1'b0;
    end

    // Trigger edge only matters with auto trigger on; starts need the converter
    if (trigger_edge) begin
      next_state.irq_status[IRQ_BIT_TRIGGER] = 1'b1;
      if (state.converter_enable) begin
        next_state.pending_start = 1'b1;
      end
    end
    if (write_start && (state.converter_enable || reg_wdata[BIT_CONVERTER_ENABLE])) begin
      next_state.pending_start = 1'b1;
    end

    // Issue a start when idle; a start while busy waits for completion
    if (state.pending_start && !state.busy && state.converter_enable) begin
      next_state.start         = 1'b1;
      next_state.first         = state.need_init;
      next_state.need_init     = 1'b0;
      next_state.busy          = 1'b1;
      next_state.pending_start = 1'b0;
    end

    // Completion; the event wins over any clear in the same cycle
    if (conv_done && state.busy) begin
      next_state.busy                       = 1'b0;
      next_state.conv_complete_flag         = 1'b1;
      next_state.irq_status[IRQ_BIT_COMPLETE] = 1'b1;
      if (!next_state.result_locked) begin
        next_state.conversion_result = conv_data;
        next_state.result_signed     = differential;
      end
    end

    // Switching into free run samples the flag as it will next stand, so a
    // stale completion flag is never seen as an edge
    if ((next_state.trigger_source_select == TRIG_FREE_RUN) &&
        (state.trigger_source_select != TRIG_FREE_RUN)) begin
      next_state.prev_trigger = next_state.conv_complete_flag;
    end

    // Disabling aborts a conversion and drops any queued start
    if (!next_state.converter_enable) begin
      next_state.busy          = 1'b0;
      next_state.pending_start = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata           = state.rdata;
  assign conv_start          = state.start;
  assign conv_first          = state.first;
  assign converter_on        = state.converter_enable;
  assign high_speed_select   = state.high_speed_select;
  assign channel_select_bits = state.channel_select_bits;
  // Completion request to the core interrupt logic
  assign conv_irq = state.conv_irq_enable && global_irq_enable && state.conv_complete_flag;
  assign irq      = |(state.irq_status & state.irq_mask);
endmodule
`default_nettype wire

// file: test/conv_result_ctrl_props.sv
// Concurrent checks on the converter control block ports.
// Assumes one clock domain and the package offsets and bit positions.
`timescale 1ns/1ps
`default_nettype none
module conv_result_ctrl_props
  import conv_ctrl_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       global_irq_enable,
  input wire logic       irq_vector_taken,
  input wire logic       conv_done,
  input wire logic       conv_start,
  input wire logic       conv_first,
  input wire logic       conv_tick,
  input wire logic       converter_on,
  input wire logic       high_speed_select,
  input wire logic       conv_irq
);
  // All checks share the system clock and its reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  irq_global_a: assert property (conv_irq |-> global_irq_enable)
    else $error("conv irq without global enable");
  irq_en_off_a: assert property (reg_write && reg_addr == OFF_CONTROL_STATUS && !reg_wdata[BIT_IRQ_ENABLE] |=> !conv_irq)
    else $error("conv irq after local disable");
  tick_gap_a: assert property (conv_tick |=> !conv_tick)
    else $error("tick spacing below two");
  tick_on_a: assert property (conv_tick |-> converter_on || $past(converter_on))
    else $error("tick while converter off");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  start_on_a: assert property (conv_start |-> converter_on)
    else $error("start while converter off");
  first_start_a: assert property (conv_first |-> conv_start)
    else $error("first without start");
  flag_clear_a: assert property (irq_vector_taken && !conv_done |=> !conv_irq)
    else $error("flag not cleared by vector");
  speed_follow_a: assert property (reg_write && reg_addr == OFF_SPECIAL_IO |=>
    high_speed_select == $past(reg_wdata[BIT_HIGH_SPEED]))
    else $error("high speed bit not taken");
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == RESET_BYTE)
    else $error("read data outside read answer");
endmodule
bind conv_result_ctrl conv_result_ctrl_props u_props (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken), .conv_done(conv_done),
  .conv_start(conv_start), .conv_first(conv_first), .conv_tick(conv_tick), .converter_on(converter_on),
  .high_speed_select(high_speed_select), .conv_irq(conv_irq));
`default_nettype wire

// file: test/conv_core_model.sv
// Behavioural analog core: counts converter ticks, then reports a code.
// Assumes conv_start only while idle, as the control block promises.
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
  import conv_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       conv_start,
  input  wire logic       conv_first,
  input  wire logic       conv_tick,
  input  wire logic [9:0] code,
  output logic            conv_done,
  output logic      [9:0] conv_data
);
  logic       busy;
  logic [4:0] cnt;

  // Data is inverted outside the done cycle so stale codes cannot pass
  assign conv_data = conv_done ? code : ~code;

  // First conversion after enable is the long one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy      <= 1'b0;
      cnt       <= 5'h00;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        busy <= 1'b1;
        cnt  <= conv_first ? 5'(FIRST_CONV_CYCLES) : 5'(NORMAL_CONV_CYCLES);
      end else if (busy && conv_tick) begin
        cnt <= cnt - 5'h01;
        if (cnt == 5'h01) begin
          busy      <= 1'b0;
          conv_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/adc_result_and_trigger_control_tb.sv
// Self-checking bench for the converter result and trigger control.
// Assumes the core model answers starts; registers driven as a plain port.
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_trigger_control_tb;
  import conv_ctrl_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic        global_irq_enable = 1'b0, irq_vector_taken = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, d, lo;
  logic [7:1]  trigger_flags = 7'h00;
  logic [9:0]  code = 10'h000, conv_data;
  logic [4:0]  channel_select_bits, ch;
  logic [15:0] e;
  logic [31:0] seed = 32'h0000002A;
  logic        conv_start, conv_first, conv_tick, converter_on, high_speed_select, conv_irq, irq, conv_done, st;
  int          num_errors = 0, cmp_count = 0, cyc = 0, n;

  conv_result_ctrl u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .trigger_flags(trigger_flags), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start(conv_start), .conv_first(conv_first), .conv_tick(conv_tick),
    .converter_on(converter_on), .high_speed_select(high_speed_select),
    .channel_select_bits(channel_select_bits), .conv_irq(conv_irq), .irq(irq));
  conv_core_model u_core (.clk(clk), .rstn(rstn), .conv_start(conv_start), .conv_first(conv_first),
    .conv_tick(conv_tick), .code(code), .conv_done(conv_done), .conv_data(conv_data));

  always #10 clk = ~clk;

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {high, low}; unused bits zero, sign copied for pairs
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic la, input logic df);
    if (la) return {c, 6'h00};
    return {{6{df & c[9]}}, c};
  endfunction

  task automatic chk(input string t, input logic [7:0] x, input logic [7:0] s);
    cmp_count++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", t, x, s);
    end
  endtask

  // Strobe for one cycle, then an idle edge before the next access
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask

  task automatic watch(input int c, output logic s);
    s = 1'b0;
    repeat (c) begin
      @(posedge clk);
      s = s | conv_start;
    end
  endtask

  task automatic wait_done();
    n = 0;
    while (conv_done !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("done", 8'h01, {7'h00, conv_done});
    repeat (2) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Result bytes ignore writes; unmapped index reads zero
    wr(OFF_RESULT_LOW, 8'hFF);
    wr(OFF_RESULT_HIGH, 8'hFF);
    wr(3'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      chk("reset value", 8'h00, d);
    end
    $display("test reset finished");
    // Second tick gap is measured; the first may straddle the change
    for (int s = 0; s < 8; s++) begin
      wr(OFF_CONTROL_STATUS, 8'h80 | 8'(s));
      repeat (2) begin
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (conv_tick !== 1'b1 && n < 300);
      end
      chk("tick gap", (s < 2) ? 8'h02 : 8'(1 << s), 8'(n));
    end
    $display("test divider finished");
    wr(OFF_IRQ_MASK, 8'h01);
    for (int k = 0; k < 6; k++) begin
      code <= (k == 0) ? 10'h3FF : (k == 1) ? 10'h200 : 10'(xs());
      global_irq_enable <= (k != 3);
      ch = k[1] ? DIFF_FIRST : 5'h00;
      wr(OFF_INPUT_SELECT, {2'b00, k[0], ch});
      chk("channel", {3'h0, ch}, {3'h0, channel_select_bits});
      wr(OFF_CONTROL_STATUS, 8'hC8);
      wait_done();
      chk("conv irq", {7'h00, k != 3}, {7'h00, conv_irq});
      chk("irq", 8'h01, {7'h00, irq});
      rd(OFF_IRQ_STATUS, d);
      chk("irq status", 8'h01, d);
      // Flip the adjustment with the result held
      for (int j = 0; j < 2; j++) begin
        wr(OFF_INPUT_SELECT, {2'b00, k[0] ^ j[0], ch});
        e = fmt(code, k[0] ^ j[0], k[1]);
        rd(OFF_RESULT_LOW, lo);
        rd(OFF_RESULT_HIGH, d);
        chk("result low", e[7:0], lo);
        chk("result high", e[15:8], d);
      end
      if (k[0]) wr(OFF_CONTROL_STATUS, 8'h98);
      else begin
        irq_vector_taken <= 1'b1;
        @(posedge clk);
        irq_vector_taken <= 1'b0;
        @(posedge clk);
      end
      global_irq_enable <= 1'b1;
      @(posedge clk);
      chk("flag clear", 8'h00, {7'h00, conv_irq});
    end
    $display("test result finished");
    // Low byte read holds the pair across a new conversion
    e = fmt(code, 1'b0, 1'b0);
    rd(OFF_RESULT_LOW, lo);
    code <= ~code;
    wr(OFF_CONTROL_STATUS, 8'hC8);
    wait_done();
    rd(OFF_RESULT_HIGH, d);
    chk("locked high", e[15:8], d);
    $display("test lock finished");
    wr(OFF_CONTROL_STATUS, 8'hB0);
    for (int s = 1; s < 8; s++) begin
      wr(OFF_SPECIAL_IO, {3'(s), 5'h00});
      code <= 10'(xs());
      trigger_flags <= 7'(1 << (s - 1));
      watch(6, st);
      chk("edge start", 8'h01, {7'h00, st});
      wait_done();
      watch(30, st);
      chk("level hold", 8'h00, {7'h00, st});
      trigger_flags <= 7'h00;
    end
    wr(OFF_CONTROL_STATUS, 8'h90);
    wr(OFF_SPECIAL_IO, 8'h20);
    trigger_flags <= 7'h03;
    watch(10, st);
    chk("auto off", 8'h00, {7'h00, st});
    trigger_flags <= 7'h02;
    wr(OFF_CONTROL_STATUS, 8'hA0);
    wr(OFF_SPECIAL_IO, 8'h40);
    watch(6, st);
    chk("source switch", 8'h01, {7'h00, st});
    wait_done();
    trigger_flags <= 7'h00;
    @(posedge clk);
    wr(OFF_SPECIAL_IO, 8'h00);
    watch(10, st);
    chk("free run", 8'h00, {7'h00, st});
    wr(OFF_CONTROL_STATUS, 8'h00);
    $display("test trigger finished");
    for (int b = 1; b >= 0; b--) begin
      wr(OFF_SPECIAL_IO, 8'(b << BIT_HIGH_SPEED));
      chk("high speed", 8'(b), {7'h00, high_speed_select});
    end
    $display("test speed finished");
    stop_test();
  end
endmodule
`default_nettype wire
